/* src/capture_timer_pkg.sv */
// register map, field layout, mode codes and bus carrier of the capture timer
// assumes a byte-wide register port with one-cycle reads and writes
package capture_timer_pkg;

  // byte offsets on the register port
  localparam logic [3:0] CTRL_A_OFFSET = 4'h0;
  localparam logic [3:0] CTRL_B_OFFSET = 4'h1;
  localparam logic [3:0] EVENT_CTRL_OFFSET = 4'h4;
  localparam logic [3:0] INT_ENABLE_OFFSET = 4'h5;
  localparam logic [3:0] INT_FLAG_OFFSET = 4'h6;
  localparam logic [3:0] RUN_STATUS_OFFSET = 4'h7;
  localparam logic [3:0] DEBUG_CTRL_OFFSET = 4'h8;
  localparam logic [3:0] STAGING_OFFSET = 4'h9;
  localparam logic [3:0] COUNT_OFFSET = 4'hA;
  localparam logic [3:0] COMPARE_OFFSET = 4'hC;
  localparam logic [3:0] HIGH_BYTE_STEP = 4'h1;
  localparam logic [3:0] COUNT_HIGH_OFFSET = COUNT_OFFSET + HIGH_BYTE_STEP;
  localparam logic [3:0] COMPARE_HIGH_OFFSET = COMPARE_OFFSET + HIGH_BYTE_STEP;

  // field positions
  localparam int ENABLE_BIT = 0;
  localparam int INPUT_ENABLE_BIT = 0;
  localparam int EDGE_BIT = 4;
  localparam int IRQ_BIT = 0;
  localparam int DEBUG_RUN_BIT = 0;
  localparam int MODE_LSB = 0;

  // writable bits of each control byte
  localparam logic [7:0] CTRL_A_MASK = 8'h57;
  localparam logic [7:0] CTRL_B_MASK = 8'h77;
  localparam logic [7:0] EVENT_CTRL_MASK = 8'h51;
  localparam logic [7:0] SINGLE_BIT_MASK = 8'h01;

  // reset values
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [15:0] WORD_RESET = 16'h0000;

  typedef enum logic [2:0] {
    mode_periodic = 3'h0,
    mode_timeout = 3'h1,
    mode_capture = 3'h2,
    mode_frequency = 3'h3,
    mode_pulse_width = 3'h4,
    mode_freq_pulse = 3'h5,
    mode_single_shot = 3'h6,
    mode_pwm8 = 3'h7
  } counter_mode_t;

  // phases of the combined frequency and pulse-width measurement
  typedef enum logic [2:0] {
    phase_first = 3'b001,
    phase_opposite = 3'b010,
    phase_second = 3'b100
  } pair_phase_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

endpackage

/* src/event_edge_detect.sv */
// rising and falling edge detector for the incoming event level
// assumes the event level is already synchronous to ref_clk
`timescale 1ns/1ps
module event_edge_detect (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic level_in,
  output logic rise,
  output logic fall
);
  logic level_reg;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      level_reg <= 1'b0;
    end else begin
      level_reg <= level_in;
    end
  end

  assign rise = level_in & ~level_reg;
  assign fall = ~level_in & level_reg;
endmodule

/* src/word_register.sv */
// 16-bit register loaded by hardware or by byte-lane bus commits
// a bus commit in the same cycle as a hardware load wins
`timescale 1ns/1ps
module word_register (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic hw_load,
  input wire logic [15:0] hw_value,
  input wire logic [1:0] bus_byte_we,
  input wire logic [15:0] bus_value,
  output logic [15:0] value_reg
);
  import capture_timer_pkg::*;

  logic [15:0] value_next;

  assign value_next[7:0] = bus_byte_we[0] ? bus_value[7:0] : (hw_load ? hw_value[7:0] : value_reg[7:0]);
  assign value_next[15:8] = bus_byte_we[1] ? bus_value[15:8] : (hw_load ? hw_value[15:8] : value_reg[15:8]);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      value_reg <= WORD_RESET;
    end else begin
      value_reg <= value_next;
    end
  end
endmodule

/* src/capture_timer.sv */
// capture timer: register file, counter modes, capture and interrupt flag
// assumes a synchronous byte register port and a synchronous event level
//
// Function
// [RULE1] input enable bit lets events drive capture and counter actions
// [RULE2] interrupt request is flag gated by interrupt enable bit 0
// [RULE3] flag clears on write one, or on compare read in capture modes
// [RULE4] periodic, time-out and single-shot set flag when counter reaches top
// [RULE5] capture mode loads compare from counter and sets flag on event
// [RULE6] frequency mode captures, restarts counter and sets flag per edge
// [RULE7] pulse-width: one edge restarts, opposite edge captures and sets flag
// [RULE8] combined mode sets flag and stops counter on second selected edge
// [RULE9] pwm mode sets flag when counter reaches compare low byte
// [RULE10] run bit reads counting state and is read-only
// [RULE11] debug run zero halts timer and ignores events while cpu halted
// [RULE12] one shared 8-bit staging byte serves all 16-bit registers
// [RULE13] low byte sits at base offset, high byte at base plus one
// [RULE14] bus write to counter beats a same-cycle internal update
// [RULE15] in capture modes compare holds counter at latest capture
// [RULE16] periodic, time-out and single-shot use compare as top value
// [RULE17] pwm mode treats compare bytes as two independent registers
// [RULE18] mode codes 0x0 through 0x7 select the eight counter modes
// [RULE19] timer operates only while enable bit 0 is one
// [RULE20] software reads low byte first and writes high byte first
`timescale 1ns/1ps
module capture_timer (
  input wire logic ref_clk,
  input wire logic rst,
  input capture_timer_pkg::bus_req_t bus_req,
  input wire logic event_in,
  input wire logic cpu_halted,
  output logic [7:0] bus_rdata,
  output logic capture_irq
);
  import capture_timer_pkg::*;

  logic [7:0] ctrl_a_reg;
  logic [7:0] ctrl_b_reg;
  logic [7:0] event_ctrl_reg;
  logic [7:0] interrupt_enable_reg;
  logic [7:0] debug_control_reg;
  logic [7:0] byte_staging_buffer;
  logic [7:0] staging_next;
  logic flag_reg;
  logic flag_next;
  logic run_reg;
  logic run_next;
  pair_phase_t phase_reg;
  pair_phase_t phase_next;
  logic [15:0] counter_value;
  logic [15:0] capture_compare_value;
  logic [15:0] count_hw_value;
  logic count_hw_load;
  logic capture_load;
  logic flag_set;
  logic ev_rise;
  logic ev_fall;
  logic [7:0] read_value;

  counter_mode_t counter_mode_field;
  wire enable_bit = ctrl_a_reg[ENABLE_BIT];
  wire capture_event_input_enable = event_ctrl_reg[INPUT_ENABLE_BIT];
  wire edge_select = event_ctrl_reg[EDGE_BIT];
  wire run_while_halted = debug_control_reg[DEBUG_RUN_BIT];
  wire irq_enable = interrupt_enable_reg[IRQ_BIT];
  assign counter_mode_field = counter_mode_t'(ctrl_b_reg[MODE_LSB +: 3]); // [RULE18]

  // decoding of the byte port
  wire wr_ctrl_a = bus_req.wr && bus_req.addr == CTRL_A_OFFSET;
  wire wr_ctrl_b = bus_req.wr && bus_req.addr == CTRL_B_OFFSET;
  wire wr_event = bus_req.wr && bus_req.addr == EVENT_CTRL_OFFSET;
  wire wr_int_en = bus_req.wr && bus_req.addr == INT_ENABLE_OFFSET;
  wire wr_flag = bus_req.wr && bus_req.addr == INT_FLAG_OFFSET;
  wire wr_debug = bus_req.wr && bus_req.addr == DEBUG_CTRL_OFFSET;
  wire wr_staging = bus_req.wr && bus_req.addr == STAGING_OFFSET;
  wire wr_count_low = bus_req.wr && bus_req.addr == COUNT_OFFSET;
  wire wr_count_high = bus_req.wr && bus_req.addr == COUNT_HIGH_OFFSET;
  wire wr_cmp_low = bus_req.wr && bus_req.addr == COMPARE_OFFSET;
  wire wr_cmp_high = bus_req.wr && bus_req.addr == COMPARE_HIGH_OFFSET;
  wire rd_count_low = bus_req.rd && bus_req.addr == COUNT_OFFSET;
  wire rd_cmp_low = bus_req.rd && bus_req.addr == COMPARE_OFFSET;

  wire pwm_mode = counter_mode_field == mode_pwm8;
  wire capture_modes = counter_mode_field inside {mode_capture, mode_frequency, mode_pulse_width, mode_freq_pulse};

  // halted cpu freezes the timer unless debug run is set
  wire active = enable_bit && (!cpu_halted || run_while_halted); // [RULE19] [RULE11]
  wire events_ok = active && capture_event_input_enable; // [RULE1] [RULE11]
  wire sel_edge = events_ok && (edge_select ? ev_fall : ev_rise);
  wire opp_edge = events_ok && (edge_select ? ev_rise : ev_fall);
  wire top_hit = counter_value == capture_compare_value; // [RULE16]
  wire pwm_hit = counter_value[7:0] == capture_compare_value[7:0]; // [RULE9] [RULE17]

  // low-byte write commits staging as the high byte, so both bytes land together
  wire [1:0] count_we = {2{wr_count_low}}; // [RULE13] [RULE20]
  wire [15:0] count_bus_value = {byte_staging_buffer, bus_req.wdata};
  wire [1:0] cmp_we = pwm_mode ? {wr_cmp_high, wr_cmp_low} : {2{wr_cmp_low}}; // [RULE17]
  wire [15:0] cmp_bus_value = pwm_mode ? {bus_req.wdata, bus_req.wdata} : {byte_staging_buffer, bus_req.wdata};

  // high-byte writes and low-byte reads, save those of compare in pwm mode, go through the one shared staging byte
  assign staging_next = (wr_staging || wr_count_high || (wr_cmp_high && !pwm_mode)) ? bus_req.wdata : // [RULE12]
                        rd_count_low ? counter_value[15:8] :
                        (rd_cmp_low && !pwm_mode) ? capture_compare_value[15:8] :
                        byte_staging_buffer;

  wire flag_clear = (wr_flag && bus_req.wdata[IRQ_BIT]) || (rd_cmp_low && capture_modes); // [RULE3]
  assign flag_next = flag_set || (flag_reg && !flag_clear); // set beats clear in the same cycle

  assign read_value = (bus_req.addr == CTRL_A_OFFSET) ? ctrl_a_reg :
                      (bus_req.addr == CTRL_B_OFFSET) ? ctrl_b_reg :
                      (bus_req.addr == EVENT_CTRL_OFFSET) ? event_ctrl_reg :
                      (bus_req.addr == INT_ENABLE_OFFSET) ? interrupt_enable_reg :
                      (bus_req.addr == INT_FLAG_OFFSET) ? {7'h00, flag_reg} :
                      (bus_req.addr == RUN_STATUS_OFFSET) ? {7'h00, run_reg} : // [RULE10]
                      (bus_req.addr == DEBUG_CTRL_OFFSET) ? debug_control_reg :
                      (bus_req.addr == STAGING_OFFSET) ? byte_staging_buffer :
                      (bus_req.addr == COUNT_OFFSET) ? counter_value[7:0] : // [RULE13]
                      (bus_req.addr == COUNT_HIGH_OFFSET) ? byte_staging_buffer :
                      (bus_req.addr == COMPARE_OFFSET) ? capture_compare_value[7:0] :
                      (bus_req.addr == COMPARE_HIGH_OFFSET) ?
                        (pwm_mode ? capture_compare_value[15:8] : byte_staging_buffer) :
                      8'h00;

  event_edge_detect u_edges (
    .ref_clk(ref_clk),
    .rst(rst),
    .level_in(event_in),
    .rise(ev_rise),
    .fall(ev_fall)
  );

  word_register u_counter (
    .ref_clk(ref_clk),
    .rst(rst),
    .hw_load(count_hw_load),
    .hw_value(count_hw_value),
    .bus_byte_we(count_we), // [RULE14]
    .bus_value(count_bus_value),
    .value_reg(counter_value)
  );

  word_register u_compare (
    .ref_clk(ref_clk),
    .rst(rst),
    .hw_load(capture_load),
    .hw_value(counter_value), // [RULE15]
    .bus_byte_we(cmp_we),
    .bus_value(cmp_bus_value),
    .value_reg(capture_compare_value)
  );

  // mode behaviour; clearing the enable bit clears run and phase, while a halt simply freezes state
  always_comb begin
    count_hw_load = 1'b0;
    count_hw_value = counter_value + 16'h0001;
    capture_load = 1'b0;
    flag_set = 1'b0;
    run_next = run_reg;
    phase_next = phase_reg;
    if (!enable_bit) begin
      run_next = 1'b0;
      phase_next = phase_first;
    end else if (active) begin
      case (counter_mode_field)
        mode_periodic: begin
          run_next = 1'b1;
          count_hw_load = 1'b1;
          if (top_hit) begin
            flag_set = 1'b1; // [RULE4]
            count_hw_value = WORD_RESET;
          end
        end
        mode_timeout: begin
          if (sel_edge) begin
            run_next = 1'b1;
          end else if (opp_edge) begin
            run_next = 1'b0;
          end
          if (run_reg) begin
            count_hw_load = 1'b1;
            if (top_hit) begin
              flag_set = 1'b1; // [RULE4]
              count_hw_value = WORD_RESET;
            end
          end
        end
        mode_capture: begin
          run_next = 1'b1;
          count_hw_load = 1'b1;
          if (sel_edge) begin
            capture_load = 1'b1; // [RULE5]
            flag_set = 1'b1;
          end
        end
        mode_frequency: begin
          run_next = 1'b1;
          count_hw_load = 1'b1;
          if (sel_edge) begin
            capture_load = 1'b1; // [RULE6]
            flag_set = 1'b1;
            count_hw_value = WORD_RESET;
          end
        end
        mode_pulse_width: begin
          run_next = 1'b1;
          count_hw_load = 1'b1;
          if (sel_edge) begin
            count_hw_value = WORD_RESET; // [RULE7]
          end else if (opp_edge) begin
            capture_load = 1'b1; // [RULE7]
            flag_set = 1'b1;
          end
        end
        mode_freq_pulse: begin
          count_hw_load = run_reg;
          case (phase_reg)
            phase_first: begin
              if (sel_edge) begin
                run_next = 1'b1;
                count_hw_load = 1'b1;
                count_hw_value = WORD_RESET;
                phase_next = phase_opposite;
              end
            end
            phase_opposite: begin
              if (opp_edge) begin
                capture_load = 1'b1;
                phase_next = phase_second;
              end
            end
            phase_second: begin
              if (sel_edge) begin
                run_next = 1'b0; // [RULE8]
                count_hw_load = 1'b0;
                flag_set = 1'b1;
                phase_next = phase_first;
              end
            end
            default: phase_next = phase_first;
          endcase
        end
        mode_single_shot: begin
          if (run_reg) begin
            count_hw_load = 1'b1;
            if (top_hit) begin
              flag_set = 1'b1; // [RULE4]
              run_next = 1'b0;
              count_hw_value = WORD_RESET;
            end
          end else if (sel_edge || (edge_select && opp_edge)) begin
            run_next = 1'b1;
            count_hw_load = 1'b1;
            count_hw_value = WORD_RESET;
          end
        end
        mode_pwm8: begin
          run_next = 1'b1;
          count_hw_load = 1'b1;
          if (pwm_hit) begin
            flag_set = 1'b1; // [RULE9]
            count_hw_value = WORD_RESET;
          end
        end
        default: run_next = run_reg;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_a_reg <= BYTE_RESET;
      ctrl_b_reg <= BYTE_RESET;
      event_ctrl_reg <= BYTE_RESET;
      interrupt_enable_reg <= BYTE_RESET;
      debug_control_reg <= BYTE_RESET;
    end else begin
      if (wr_ctrl_a) ctrl_a_reg <= bus_req.wdata & CTRL_A_MASK;
      if (wr_ctrl_b) ctrl_b_reg <= bus_req.wdata & CTRL_B_MASK;
      if (wr_event) event_ctrl_reg <= bus_req.wdata & EVENT_CTRL_MASK;
      if (wr_int_en) interrupt_enable_reg <= bus_req.wdata & SINGLE_BIT_MASK;
      if (wr_debug) debug_control_reg <= bus_req.wdata & SINGLE_BIT_MASK;
    end
  end

  // run state has no bus write path at all
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      byte_staging_buffer <= BYTE_RESET;
      flag_reg <= 1'b0;
      run_reg <= 1'b0;
      phase_reg <= phase_first;
      bus_rdata <= BYTE_RESET;
      capture_irq <= 1'b0;
    end else begin
      byte_staging_buffer <= staging_next;
      flag_reg <= flag_next;
      run_reg <= run_next; // [RULE10]
      phase_reg <= phase_next;
      bus_rdata <= bus_req.rd ? read_value : BYTE_RESET;
      capture_irq <= flag_reg && irq_enable; // [RULE2]
    end
  end

  wire count_bus_touch = wr_count_low;
  wire cmp_bus_touch = wr_cmp_low || wr_cmp_high;

  sequence s_capture_event;
    counter_mode_field == mode_capture && sel_edge && !cmp_bus_touch;
  endsequence

  sequence s_loaded_with_count;
    flag_reg && capture_compare_value == $past(counter_value);
  endsequence

  property p_events_ignored;
    @(posedge ref_clk) disable iff (rst)
      !capture_event_input_enable && capture_modes && !cmp_bus_touch |=> $stable(capture_compare_value);
  endproperty
  a_events_ignored: assert property (p_events_ignored) else $error("capture taken with input disabled"); // [RULE1]

  property p_irq_gate;
    @(posedge ref_clk) disable iff (rst)
      capture_irq |-> $past(irq_enable) && $past(flag_reg);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt raised without enable and flag"); // [RULE2]

  property p_write_one_clears;
    @(posedge ref_clk) disable iff (rst)
      wr_flag && bus_req.wdata[IRQ_BIT] && !flag_set |=> !flag_reg ##1 !capture_irq;
  endproperty
  a_write_one_clears: assert property (p_write_one_clears) else $error("flag survived write of one"); // [RULE3]

  property p_periodic_top;
    @(posedge ref_clk) disable iff (rst)
      counter_mode_field == mode_periodic && active && top_hit && !count_bus_touch
      |=> flag_reg && counter_value == 16'h0000;
  endproperty
  a_periodic_top: assert property (p_periodic_top) else $error("top reached without flag and wrap"); // [RULE4]

  property p_capture_event;
    @(posedge ref_clk) disable iff (rst)
      s_capture_event |=> s_loaded_with_count;
  endproperty
  a_capture_event: assert property (p_capture_event) else $error("event did not capture the count"); // [RULE5]

  property p_frequency_edge;
    @(posedge ref_clk) disable iff (rst)
      counter_mode_field == mode_frequency && sel_edge && !cmp_bus_touch && !count_bus_touch
      |=> s_loaded_with_count and counter_value == 16'h0000;
  endproperty
  a_frequency_edge: assert property (p_frequency_edge) else $error("frequency edge missed capture or restart"); // [RULE6]

  property p_run_off_when_disabled;
    @(posedge ref_clk) disable iff (rst)
      !enable_bit |=> !run_reg;
  endproperty
  a_run_off_when_disabled: assert property (p_run_off_when_disabled) else $error("running while disabled"); // [RULE10]

  property p_debug_halt;
    @(posedge ref_clk) disable iff (rst)
      cpu_halted && !run_while_halted && !count_bus_touch |=> $stable(counter_value) && $stable(run_reg);
  endproperty
  a_debug_halt: assert property (p_debug_halt) else $error("timer moved while cpu halted"); // [RULE11]

  property p_write_wins;
    @(posedge ref_clk) disable iff (rst)
      wr_count_low |=> counter_value == {$past(byte_staging_buffer), $past(bus_req.wdata)};
  endproperty
  a_write_wins: assert property (p_write_wins) else $error("counter write lost to internal update"); // [RULE14]
endmodule

/* sim/event_source.sv */
// stand-in for the event system: drives the event level seen by the timer
// assumes the bench calls drive from one process at a time
`timescale 1ns/1ps
module event_source (
  input wire logic ref_clk,
  output logic event_in
);
  initial begin
    event_in = 1'b0;
  end
  // level moves only just after a clock edge, like a synchronous event channel
  task automatic drive(input logic v);
    @(posedge ref_clk);
    event_in <= v;
  endtask
endmodule

/* sim/capture_timer_bench.sv */
// self-checking bench for the capture timer register file and counter modes
// assumes the event_source model and the design package are compiled first
`timescale 1ns/1ps
module capture_timer_bench;
  import capture_timer_pkg::*;
  logic ref_clk;
  logic rst;
  logic cpu_halted;
  logic event_in;
  logic capture_irq;
  logic [7:0] bus_rdata;
  logic [7:0] q;
  logic [15:0] v0;
  logic [15:0] v1;
  bus_req_t bus_req;
  int bad_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  int t0;

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  capture_timer dut_u (
    .ref_clk(ref_clk),
    .rst(rst),
    .bus_req(bus_req),
    .event_in(event_in),
    .cpu_halted(cpu_halted),
    .bus_rdata(bus_rdata),
    .capture_irq(capture_irq)
  );

  event_source ev_u (
    .ref_clk(ref_clk),
    .event_in(event_in)
  );

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // whole run needs well under 2000 cycles; the ceiling leaves wide margin
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count = bad_count + 1;
      report_and_stop();
    end
  end

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one idle value for every release, so the bus strobes have a single constant source
  task automatic bus_idle();
    bus_req <= '0;
  endtask

  task automatic set_halt(input logic v);
    @(posedge ref_clk);
    cpu_halted <= v;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus_idle();
  endtask

  // read data is registered, so it is sampled mid-cycle after the taking edge
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus_idle();
    @(negedge ref_clk);
    d = bus_rdata;
  endtask

  task automatic expect_rd(input logic [3:0] a, input logic [7:0] exp, input string name);
    logic [7:0] d;
    rd(a, d);
    check(name, {8'h00, exp}, {8'h00, d});
  endtask

  // low byte first so the high byte comes back from the same instant
  task automatic rd16(input logic [3:0] a, output logic [15:0] w);
    logic [7:0] lo;
    logic [7:0] hi;
    rd(a, lo);
    rd(a + 4'h1, hi);
    w = {hi, lo};
  endtask

  task automatic wr16(input logic [3:0] a, input logic [15:0] w);
    wr(a + 4'h1, w[15:8]);
    wr(a, w[7:0]);
  endtask

  task automatic rise_at(input int t);
    while (cyc < t) @(posedge ref_clk);
    ev_u.drive(1'b1);
  endtask

  task automatic fall_at(input int t);
    while (cyc < t) @(posedge ref_clk);
    ev_u.drive(1'b0);
  endtask

  task automatic t_reset();
    logic [3:0] offs [10] = '{4'h2, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD};
    foreach (offs[i]) expect_rd(offs[i], 8'h00, "reset value");
  endtask

  task automatic t_bytes();
    wr(STAGING_OFFSET, 8'hA5);
    expect_rd(STAGING_OFFSET, 8'hA5, "staging byte");
    wr(RUN_STATUS_OFFSET, 8'hFF);
    expect_rd(RUN_STATUS_OFFSET, 8'h00, "run status write");
    wr(4'h2, 8'hFF);
    expect_rd(4'h2, 8'h00, "unmapped offset");
    for (int m = 0; m < 8; m++) begin
      wr(CTRL_B_OFFSET, 8'(m));
      expect_rd(CTRL_B_OFFSET, 8'(m), "mode code");
    end
  endtask

  task automatic t_word();
    wr16(COUNT_OFFSET, 16'h1234);
    rd16(COUNT_OFFSET, v0);
    check("counter word", 16'h1234, v0);
    expect_rd(STAGING_OFFSET, 8'h12, "staging after low read");
  endtask

  task automatic t_periodic();
    wr16(COMPARE_OFFSET, 16'h0005);
    wr16(COUNT_OFFSET, 16'h0000);
    wr(CTRL_B_OFFSET, 8'h00);
    wr(CTRL_A_OFFSET, 8'h01);
    repeat (10) @(posedge ref_clk);
    expect_rd(RUN_STATUS_OFFSET, 8'h01, "run while enabled");
    expect_rd(INT_FLAG_OFFSET, 8'h01, "flag at top");
    check("irq masked", 16'h0000, {15'h0, capture_irq});
    wr(INT_ENABLE_OFFSET, 8'h01);
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    check("irq enabled", 16'h0001, {15'h0, capture_irq});
    wr(CTRL_A_OFFSET, 8'h00);
    wr(INT_FLAG_OFFSET, 8'h01);
    expect_rd(INT_FLAG_OFFSET, 8'h00, "flag write one");
    expect_rd(RUN_STATUS_OFFSET, 8'h00, "run when disabled");
    check("irq after clear", 16'h0000, {15'h0, capture_irq});
  endtask

  task automatic t_capture();
    wr(CTRL_B_OFFSET, 8'h02);
    wr(CTRL_A_OFFSET, 8'h01);
    ev_u.drive(1'b1);
    repeat (3) @(posedge ref_clk);
    expect_rd(INT_FLAG_OFFSET, 8'h00, "event ignored");
    ev_u.drive(1'b0);
    wr(EVENT_CTRL_OFFSET, 8'h01);
    t0 = cyc + 2;
    rise_at(t0);
    repeat (2) @(posedge ref_clk);
    expect_rd(INT_FLAG_OFFSET, 8'h01, "flag on capture");
    rd16(COMPARE_OFFSET, v0);
    expect_rd(INT_FLAG_OFFSET, 8'h00, "flag cleared by read");
    ev_u.drive(1'b0);
    rise_at(t0 + 60);
    repeat (2) @(posedge ref_clk);
    rd16(COMPARE_OFFSET, v1);
    check("capture spacing", 16'd60, v1 - v0);
  endtask

  task automatic t_frequency();
    wr(CTRL_B_OFFSET, 8'h03);
    ev_u.drive(1'b0);
    t0 = cyc + 4;
    rise_at(t0);
    ev_u.drive(1'b0);
    rise_at(t0 + 30);
    ev_u.drive(1'b0);
    rd16(COMPARE_OFFSET, v0);
    rise_at(t0 + 60);
    ev_u.drive(1'b0);
    expect_rd(INT_FLAG_OFFSET, 8'h01, "frequency flag");
    rd16(COMPARE_OFFSET, v1);
    check("period capture repeat", v0, v1);
  endtask

  // widths of 20 and 50 cycles: the captured values must differ by exactly 30
  task automatic t_pulse();
    wr(CTRL_B_OFFSET, 8'h04);
    t0 = cyc + 4;
    rise_at(t0);
    fall_at(t0 + 20);
    repeat (2) @(posedge ref_clk);
    expect_rd(INT_FLAG_OFFSET, 8'h01, "pulse flag");
    rd16(COMPARE_OFFSET, v0);
    rise_at(t0 + 80);
    fall_at(t0 + 130);
    repeat (2) @(posedge ref_clk);
    rd16(COMPARE_OFFSET, v1);
    check("pulse width spacing", 16'd30, v1 - v0);
  endtask

  // high time 10, period 40: stopped count minus captured width is 30
  task automatic t_pair();
    wr(CTRL_B_OFFSET, 8'h05);
    t0 = cyc + 4;
    rise_at(t0);
    fall_at(t0 + 10);
    rise_at(t0 + 40);
    ev_u.drive(1'b0);
    repeat (2) @(posedge ref_clk);
    rd16(COUNT_OFFSET, v0);
    expect_rd(RUN_STATUS_OFFSET, 8'h00, "pair stopped");
    expect_rd(INT_FLAG_OFFSET, 8'h01, "pair flag");
    rd16(COMPARE_OFFSET, v1);
    check("pair period minus width", 16'd30, v0 - v1);
  endtask

  task automatic t_single();
    wr(CTRL_A_OFFSET, 8'h00);
    wr(CTRL_B_OFFSET, 8'h06);
    wr16(COMPARE_OFFSET, 16'h0010);
    wr(CTRL_A_OFFSET, 8'h01);
    expect_rd(RUN_STATUS_OFFSET, 8'h00, "single shot idle");
    ev_u.drive(1'b1);
    expect_rd(RUN_STATUS_OFFSET, 8'h01, "single shot running");
    repeat (30) @(posedge ref_clk);
    expect_rd(INT_FLAG_OFFSET, 8'h01, "single shot top");
    expect_rd(RUN_STATUS_OFFSET, 8'h00, "single shot stopped");
    rd16(COUNT_OFFSET, v0);
    check("single shot rewound", 16'h0000, v0);
    wr(INT_FLAG_OFFSET, 8'h01);
    wr(CTRL_B_OFFSET, 8'h01);
    ev_u.drive(1'b0);
    ev_u.drive(1'b1);
    repeat (30) @(posedge ref_clk);
    expect_rd(INT_FLAG_OFFSET, 8'h01, "timeout top");
    ev_u.drive(1'b0);
    rd16(COUNT_OFFSET, v0);
    rd16(COUNT_OFFSET, v1);
    check("timeout stop", v0, v1);
    expect_rd(RUN_STATUS_OFFSET, 8'h00, "timeout stopped");
  endtask

  task automatic t_debug();
    wr(CTRL_B_OFFSET, 8'h00);
    wr16(COMPARE_OFFSET, 16'hFFFF);
    set_halt(1'b1);
    rd16(COUNT_OFFSET, v0);
    rd16(COUNT_OFFSET, v1);
    check("frozen in break", v0, v1);
    wr(DEBUG_CTRL_OFFSET, 8'h01);
    rd16(COUNT_OFFSET, v0);
    rd16(COUNT_OFFSET, v1);
    check("runs in break", 16'h0001, {15'h0, v1 != v0});
    wr16(COUNT_OFFSET, 16'h1000);
    rd16(COUNT_OFFSET, v0);
    check("count write while running", 16'h0010, {8'h00, v0[15:8]});
    set_halt(1'b0);
  endtask

  task automatic t_pwm();
    wr(CTRL_A_OFFSET, 8'h00);
    wr(CTRL_B_OFFSET, 8'h07);
    wr(STAGING_OFFSET, 8'h77);
    wr(COMPARE_HIGH_OFFSET, 8'h33);
    wr(COMPARE_OFFSET, 8'h44);
    expect_rd(COMPARE_HIGH_OFFSET, 8'h33, "pwm high byte");
    expect_rd(COMPARE_OFFSET, 8'h44, "pwm low byte");
    expect_rd(STAGING_OFFSET, 8'h77, "staging untouched");
    wr(INT_FLAG_OFFSET, 8'h01);
    expect_rd(INT_FLAG_OFFSET, 8'h00, "pwm flag idle");
    wr(CTRL_A_OFFSET, 8'h01);
    repeat (300) @(posedge ref_clk);
    expect_rd(INT_FLAG_OFFSET, 8'h01, "pwm flag");
    rd16(COUNT_OFFSET, v0);
    check("pwm wrap at low byte", 16'h0001, {15'h0, v0 <= 16'h0044});
    wr(CTRL_A_OFFSET, 8'h00);
  endtask

  initial begin
    rst = 1'b1;
    bus_req = '0;
    set_halt(1'b0);
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset();
    t_bytes();
    t_word();
    t_periodic();
    t_capture();
    t_frequency();
    t_pulse();
    t_pair();
    t_single();
    t_debug();
    t_pwm();
    report_and_stop();
  end
endmodule
